// file: inc/nibble_bus_pkg.sv
package nibble_bus_pkg;

    // ----------------------------------------
    // field codes
    // ----------------------------------------
    localparam logic [3:0] START_READ = 4'hD;
    localparam logic [3:0] WAIT_SYNC = 4'h5;
    localparam logic [3:0] READY_SYNC = 4'h0;
    localparam logic [3:0] TURN_ONES = 4'hF;
    localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;

    // ----------------------------------------
    // address layout and timing counts
    // ----------------------------------------
    localparam int NIBBLE_WIDTH = 4;
    localparam int ADDRESS_WIDTH = 28;
    localparam int DECODE_WIDTH = 20;
    localparam int FLASH_SELECT_BIT = 22;
    localparam logic [2:0] ADDRESS_NIBBLES = 3'h7;
    localparam logic [2:0] MIN_WAIT_SYNCS = 3'h2;
    localparam int BYTE_WIDTH = 8;
    localparam logic [1:0] BUFFER_DEPTH = 2'h2;

    // ----------------------------------------
    // cycle states
    // ----------------------------------------
    typedef enum logic [3:0] {
        phase_idle,
        phase_select,
        phase_address,
        phase_size,
        phase_turn_in,
        phase_take_bus,
        phase_wait,
        phase_ready,
        phase_data_low,
        phase_data_high,
        phase_turn_out,
        phase_release
    } cycle_phase_type;

endpackage

// file: rtl/nibble_bus_byte_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module nibble_bus_byte_buffer
    import nibble_bus_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    input wire logic [BYTE_WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [BYTE_WIDTH-1:0] out_data,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][BYTE_WIDTH-1:0] word;
        logic head;
        logic [1:0] count;
    } buffer_state_type;

    buffer_state_type state;
    buffer_state_type next_state;
    logic push;
    logic pop;

    assign in_ready = state.count != BUFFER_DEPTH;
    assign out_valid = state.count != 2'h0;
    assign out_data = state.word[state.head];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_state = state;
        if (push) begin
            next_state.word[state.head ^ state.count[0]] = in_data;
        end
        if (pop) begin
            next_state.head = ~state.head;
        end
        next_state.count = state.count + {1'b0, push} - {1'b0, pop};
        // a flush drops bytes left over from an aborted cycle
        if (flush) begin
            next_state.count = 2'h0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    default clocking buffer_clk @(posedge clock); endclocking
    default disable iff (reset);

    never_overfill_a: assert property (state.count <= BUFFER_DEPTH)
        else $error("buffer count above depth");
    stall_holds_a: assert property (state.count == BUFFER_DEPTH && !pop && !flush
        |=> !in_ready)
        else $error("buffer not full after stall");
    buffer_fills_c: cover property (state.count == BUFFER_DEPTH);

endmodule

`default_nettype wire

// file: rtl/nibble_bus_read_cycle.sv
// Contract
// - every field is one four-bit nibble
// - fields sampled on the rising clock edge
// - read starts with 1101, strobe low
// - only the last start nibble counts
// - continue only if select matches straps
// - size nibble 0000, single byte only
// - device takes bus in clock 12
// - wait-sync 0101 in clocks 13, 14
// - ready-sync 0000 in clock 15
// - low nibble clock 16, high 17
// - further bytes need waits, ready, data
// - drive 1111 then release the bus
// - bad size resets, no response
// - strobe low aborts and tri-states now
// - decode only the low 20 bits
// - address bit 22 selects flash or registers
`timescale 1ns/100ps
`default_nettype none

module nibble_bus_read_cycle
    import nibble_bus_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // shared nibble bus
    input wire logic frame_strobe_n,
    input wire logic [NIBBLE_WIDTH-1:0] nibble_bus_in,
    output logic [NIBBLE_WIDTH-1:0] nibble_bus_out,
    output logic nibble_bus_oe_n,
    // straps
    input wire logic [NIBBLE_WIDTH-1:0] strapped_id_inputs,
    // request to the storage core
    output logic read_request,
    output logic [DECODE_WIDTH-1:0] read_address,
    output logic read_flash_select,
    // byte answer from the storage core
    input wire logic read_data_valid,
    input wire logic [BYTE_WIDTH-1:0] read_data,
    output logic read_data_ready
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        cycle_phase_type phase;
        logic [2:0] count;
        logic [ADDRESS_WIDTH-1:0] address;
        logic [BYTE_WIDTH-1:0] data;
        logic drive_n;
        logic [NIBBLE_WIDTH-1:0] out_nibble;
        logic request;
        logic [DECODE_WIDTH-1:0] req_address;
        logic req_flash;
    } read_state_type;

    read_state_type state;
    read_state_type next_state;
    logic buffer_valid;
    logic [BYTE_WIDTH-1:0] buffer_data;
    logic take_byte;
    logic wait_done;

    // ----------------------------------------
    // byte buffer between core and bus
    // ----------------------------------------
    assign wait_done = state.count >= MIN_WAIT_SYNCS - 3'h1;
    assign take_byte = state.phase == phase_wait && wait_done && frame_strobe_n;

    nibble_bus_byte_buffer answer_buffer (
        .clock(clock),
        .reset(reset),
        .flush(!frame_strobe_n),
        .in_valid(read_data_valid),
        .in_data(read_data),
        .in_ready(read_data_ready),
        .out_valid(buffer_valid),
        .out_data(buffer_data),
        .out_ready(take_byte)
    );

    // ----------------------------------------
    // cycle sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_state.request = 1'b0;
        case (state.phase)
            phase_idle: begin
            end
            phase_select: begin
                next_state.count = 3'h0;
                if (nibble_bus_in == strapped_id_inputs) begin
                    next_state.phase = phase_address;
                end else begin
                    next_state.phase = phase_idle;
                end
            end
            phase_address: begin
                // most significant nibble arrives first
                next_state.address = {state.address[ADDRESS_WIDTH-5:0], nibble_bus_in};
                next_state.count = state.count + 3'h1;
                if (state.count == ADDRESS_NIBBLES - 3'h1) begin
                    next_state.phase = phase_size;
                end
            end
            phase_size: begin
                if (nibble_bus_in == SIZE_ONE_BYTE) begin
                    next_state.request = 1'b1;
                    next_state.req_address = state.address[DECODE_WIDTH-1:0];
                    next_state.req_flash = state.address[FLASH_SELECT_BIT];
                    next_state.phase = phase_turn_in;
                end else begin
                    next_state.phase = phase_idle;
                end
            end
            phase_turn_in: begin
                next_state.phase = phase_take_bus;
            end
            phase_take_bus: begin
                next_state.count = 3'h0;
                next_state.phase = phase_wait;
            end
            phase_wait: begin
                // a slow core simply stretches the wait-syncs
                if (!wait_done) begin
                    next_state.count = state.count + 3'h1;
                end else if (buffer_valid) begin
                    next_state.data = buffer_data;
                    next_state.phase = phase_ready;
                end
            end
            phase_ready: begin
                next_state.phase = phase_data_low;
            end
            phase_data_low: begin
                next_state.phase = phase_data_high;
            end
            phase_data_high: begin
                next_state.phase = phase_turn_out;
            end
            phase_turn_out: begin
                next_state.phase = phase_release;
            end
            phase_release: begin
                next_state.phase = phase_idle;
            end
            default: begin
                next_state.phase = phase_idle;
            end
        endcase
        // strobe low aborts anything; each new start restarts, so the last wins
        if (!frame_strobe_n) begin
            next_state.request = 1'b0;
            if (nibble_bus_in == START_READ) begin
                next_state.phase = phase_select;
            end else begin
                next_state.phase = phase_idle;
            end
        end
        // output fields are registered one clock ahead of their bus clock
        next_state.drive_n = 1'b0;
        case (next_state.phase)
            phase_wait: next_state.out_nibble = WAIT_SYNC;
            phase_ready: next_state.out_nibble = READY_SYNC;
            phase_data_low: next_state.out_nibble = next_state.data[3:0];
            phase_data_high: next_state.out_nibble = next_state.data[7:4];
            phase_turn_out: next_state.out_nibble = TURN_ONES;
            default: begin
                next_state.out_nibble = TURN_ONES;
                next_state.drive_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.drive_n <= 1'b1;
            state.out_nibble <= TURN_ONES;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // the strobe gates the enable directly so an abort floats the bus at once
    assign nibble_bus_oe_n = state.drive_n || !frame_strobe_n;
    assign nibble_bus_out = state.out_nibble;
    assign read_request = state.request;
    assign read_address = state.req_address;
    assign read_flash_select = state.req_flash;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cycle_clk @(posedge clock); endclocking
    default disable iff (reset);

    start_taken_a: assert property (!frame_strobe_n && nibble_bus_in == START_READ
        |=> state.phase == phase_select)
        else $error("start nibble not taken");
    id_mismatch_a: assert property (state.phase == phase_select && frame_strobe_n
        && nibble_bus_in != strapped_id_inputs |=> nibble_bus_oe_n [*2])
        else $error("bus driven after select mismatch");
    size_reject_a: assert property (state.phase == phase_size && frame_strobe_n
        && nibble_bus_in != SIZE_ONE_BYTE |=> state.phase == phase_idle && !read_request)
        else $error("bad size not rejected");
    address_decode_a: assert property (state.phase == phase_size && frame_strobe_n
        && nibble_bus_in == SIZE_ONE_BYTE |=> read_request
        && read_address == $past(state.address[DECODE_WIDTH-1:0])
        && read_flash_select == $past(state.address[FLASH_SELECT_BIT]))
        else $error("request address wrong");
    take_bus_a: assert property (state.phase == phase_take_bus && frame_strobe_n
        ##1 frame_strobe_n |-> !nibble_bus_oe_n && nibble_bus_out == WAIT_SYNC)
        else $error("wait-sync not driven after turnaround");
    two_waits_a: assert property (state.phase == phase_ready
        |-> $past(state.phase, 1) == phase_wait && $past(state.phase, 2) == phase_wait)
        else $error("fewer than two wait-syncs");
    data_order_a: assert property (state.phase == phase_ready && frame_strobe_n
        ##1 frame_strobe_n [*2] |-> nibble_bus_out == state.data[7:4]
        && $past(nibble_bus_out) == state.data[3:0] && $past(nibble_bus_out, 2) == READY_SYNC)
        else $error("ready or data nibbles wrong");
    release_bus_a: assert property (state.phase == phase_turn_out
        |-> nibble_bus_out == TURN_ONES ##1 nibble_bus_oe_n)
        else $error("bus not released after ones");
    abort_float_a: assert property (!frame_strobe_n |-> nibble_bus_oe_n)
        else $error("bus driven with strobe low");
    idle_float_a: assert property (state.phase == phase_idle |-> nibble_bus_oe_n)
        else $error("bus driven while idle");

    full_read_c: cover property (state.phase == phase_turn_out);
    mismatch_c: cover property (state.phase == phase_select
        && nibble_bus_in != strapped_id_inputs);
    abort_wait_c: cover property (state.phase == phase_wait && !frame_strobe_n);

endmodule

`default_nettype wire

// file: test/nibble_bus_read_cycle_bench.sv
`timescale 1ns/100ps
`default_nettype none

module nibble_bus_read_cycle_bench import nibble_bus_pkg::*;;
    localparam logic [3:0] STRAP = 4'hA;
    logic [3:0] strap;
    logic core_valid;
    logic [7:0] core_byte;
    logic stuff_valid = 1'b0;
    logic clock;
    logic reset;
    logic frame_strobe_n;
    logic [3:0] bus_level;
    logic [3:0] nibble_bus_out;
    logic nibble_bus_oe_n;
    logic read_request;
    logic [19:0] read_address;
    logic read_flash_select;
    logic read_data_valid;
    logic [7:0] read_data;
    logic read_data_ready;
    logic [19:0] seen_addr;
    logic seen_flash;
    int core_delay = 0;
    int req_count = 0;
    int drive_count = 0;
    int bad_count = 0;
    int samples_checked = 0;

    nibble_host_model host (.clock(clock), .dev_out(nibble_bus_out),
        .dev_oe_n(nibble_bus_oe_n), .frame_strobe_n(frame_strobe_n), .bus_level(bus_level));

    nibble_bus_read_cycle dut (.clock(clock), .reset(reset), .frame_strobe_n(frame_strobe_n),
        .nibble_bus_in(bus_level), .nibble_bus_out(nibble_bus_out),
        .nibble_bus_oe_n(nibble_bus_oe_n), .strapped_id_inputs(strap),
        .read_request(read_request), .read_address(read_address),
        .read_flash_select(read_flash_select), .read_data_valid(read_data_valid),
        .read_data(read_data), .read_data_ready(read_data_ready));

    // ----------------------------------------
    // clock, drive monitor, storage core
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // sampled just after the falling edge so host changes have landed
    always @(negedge clock) #1 if (nibble_bus_oe_n === 1'b0) drive_count++;

    // the core and the buffer scenario each own one source of the byte input
    assign read_data_valid = core_valid || stuff_valid;
    assign read_data = stuff_valid ? 8'h77 : core_byte;

    initial begin
        core_valid = 1'b0;
        core_byte = 8'h00;
        forever begin
            @(negedge clock);
            if (read_request === 1'b1) begin
                req_count++;
                seen_addr = read_address;
                seen_flash = read_flash_select;
                repeat (core_delay) @(negedge clock);
                core_valid = 1'b1;
                core_byte = seen_addr[7:0] ^ (seen_flash ? 8'hA5 : 8'h3C);
                while (read_data_ready !== 1'b1) @(negedge clock);
                @(negedge clock);
                core_valid = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic expect_reply(input logic [7:0] exp, input logic slow);
        int w;
        w = 0;
        #1 check(nibble_bus_oe_n, 1'b1);
        @(negedge clock);
        while (nibble_bus_oe_n === 1'b0 && nibble_bus_out === WAIT_SYNC && w < 40) begin
            w++;
            @(negedge clock);
        end
        check(slow ? w > 2 : w == 2, 1'b1);
        check({nibble_bus_oe_n, nibble_bus_out}, {1'b0, READY_SYNC});
        @(negedge clock);
        check({nibble_bus_oe_n, nibble_bus_out}, {1'b0, exp[3:0]});
        @(negedge clock);
        check({nibble_bus_oe_n, nibble_bus_out}, {1'b0, exp[7:4]});
        @(negedge clock);
        check({nibble_bus_oe_n, nibble_bus_out}, {1'b0, TURN_ONES});
        @(negedge clock);
        check(nibble_bus_oe_n, 1'b1);
    endtask

    task automatic run_read(input logic [27:0] addr, input int delay);
        int n;
        n = req_count;
        core_delay = delay;
        host.request(4'hE, START_READ, strap, addr, SIZE_ONE_BYTE);
        expect_reply(addr[7:0] ^ (addr[22] ? 8'hA5 : 8'h3C), delay > 0);
        check(req_count, n + 1);
        check(seen_addr, addr[19:0]);
        check(seen_flash, addr[22]);
    endtask

    task automatic run_silent(input logic [3:0] lead, last, id, size);
        int n;
        int d;
        n = req_count;
        d = drive_count;
        host.request(lead, last, id, 28'h0400123, size);
        repeat (12) @(negedge clock);
        check(req_count, n);
        check(drive_count, d);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reads;
        run_read(28'hF45A6C3, 0);
        // a different strap value must be followed as well
        strap = 4'h3;
        run_read(28'h0012345, 0);
        strap = STRAP;
        run_read(28'h07FFF80, 6);
        $display("test reads done");
    endtask

    task automatic t_refused;
        for (int i = 0; i < 16; i++) begin
            if (i[3:0] != STRAP) begin
                run_silent(4'hE, START_READ, i[3:0], 4'h0);
            end
        end
        for (int i = 1; i < 16; i++) run_silent(4'hE, START_READ, STRAP, i[3:0]);
        run_silent(START_READ, 4'hE, STRAP, SIZE_ONE_BYTE);
        $display("test refused done");
    endtask

    task automatic t_abort;
        int d;
        core_delay = 10;
        host.request(4'hE, START_READ, STRAP, 28'h0400010, SIZE_ONE_BYTE);
        repeat (2) @(negedge clock);
        check(nibble_bus_out, WAIT_SYNC);
        host.put(1'b0, TURN_ONES, 1'b1);
        #1 check(nibble_bus_oe_n, 1'b1);
        d = drive_count;
        repeat (14) host.put(1'b0, TURN_ONES, 1'b1);
        host.put(1'b1, TURN_ONES, 1'b0);
        check(drive_count, d);
        run_read(28'h04000C4, 0);
        $display("test abort done");
    endtask

    // a full buffer refuses, and a strobe low drops stale bytes
    task automatic t_buffer;
        @(negedge clock);
        check(read_data_ready, 1'b1);
        stuff_valid = 1'b1;
        @(negedge clock);
        check(read_data_ready, 1'b1);
        @(negedge clock);
        check(read_data_ready, 1'b0);
        stuff_valid = 1'b0;
        host.put(1'b0, TURN_ONES, 1'b1);
        host.put(1'b1, TURN_ONES, 1'b0);
        check(read_data_ready, 1'b1);
        run_read(28'h0000081, 0);
        $display("test buffer done");
    endtask

    initial begin
        reset = 1'b1;
        strap = STRAP;
        repeat (12) @(negedge clock);
        check({nibble_bus_oe_n, nibble_bus_out, read_request}, {1'b1, TURN_ONES, 1'b0});
        reset = 1'b0;
        t_reads;
        t_refused;
        t_abort;
        t_buffer;
        end_sim;
    end

    // the tests need about 900 cycles
    initial begin
        #(5000 * 20);
        bad_count++;
        end_sim;
    end
endmodule

`default_nettype wire

// file: test/nibble_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module nibble_host_model
    import nibble_bus_pkg::*;
(
    // clock
    input wire logic clock,
    // device side of the shared bus
    input wire logic [3:0] dev_out,
    input wire logic dev_oe_n,
    // strobe and resolved bus level
    output var logic frame_strobe_n,
    output logic [3:0] bus_level
);
    logic host_oe;
    logic [3:0] host_val;
    logic [3:0] last_level = 4'hF;

    // no pull-up: a floating bus shows the inverse of its last level
    assign bus_level = !dev_oe_n ? dev_out : (host_oe ? host_val : ~last_level);

    always @(posedge clock) last_level <= bus_level;

    initial begin
        frame_strobe_n = 1'b1;
        host_oe = 1'b0;
        host_val = 4'hF;
    end

    // one field per cycle, changed at the falling edge so it is valid at the rising one
    task automatic put(input logic strobe_n, input logic [3:0] nib, input logic drive);
        @(negedge clock);
        frame_strobe_n = strobe_n;
        host_val = nib;
        host_oe = drive;
    endtask

    task automatic request(input logic [3:0] lead, last, id, input logic [27:0] addr,
        input logic [3:0] size);
        put(1'b0, lead, 1'b1);
        put(1'b0, last, 1'b1);
        put(1'b1, id, 1'b1);
        // single byte reads need no page alignment
        for (int i = 6; i >= 0; i--) put(1'b1, addr[i*4 +: 4], 1'b1);
        put(1'b1, size, 1'b1);
        put(1'b1, TURN_ONES, 1'b1);
        put(1'b1, TURN_ONES, 1'b0);
    endtask
endmodule

`default_nettype wire
